/* File: bench/rct_reset_ctrl_asserts.sv */
// Checker for the reset controller: reset kinds, host ports, chain test.
// Assumes it is bound to every rct_reset_ctrl instance.
`timescale 1ns/1ns
module rct_reset_ctrl_asserts (
    // Clock and reset
    input wire logic         clk_sys,
    input wire logic         sys_rst,
    // Pins
    input wire logic         reset_pin_n,
    input wire logic [49:0]  chain_pin_in,
    input wire logic         inta_o,
    input wire logic         inta_oe_n,
    input wire logic         bus_pins_input_only,
    input wire logic         chain_test_mode,
    // Host side
    input rct_pkg::rct_io_req_t  io_req,
    input wire logic         bus_req_active,
    input wire logic         master_xfer_pending,
    // Reset side
    input rct_pkg::rct_rst_ind_t rst_ind,
    input wire logic         hw_reset_hold,
    input wire logic         bus_req_withdraw,
    input wire logic         eeprom_load_start,
    input wire logic         dword_io_mode_bit,
    input wire logic [7:0]   register_address_port
);
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic       rst_sel;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Reset port moves with the I/O mode
    assign rst_sel = io_req.valid && io_req.offset == (dword_io_mode_bit ?
                     rct_pkg::OFS_RESET_DWORD : rct_pkg::OFS_RESET_WORD);

    always_comb begin
        nxt_cnt = 8'h00;
        if (chain_test_mode && cnt_ff != 8'hff) begin
            nxt_cnt = cnt_ff + 8'h01;
        end else if (chain_test_mode) begin
            nxt_cnt = cnt_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        cnt_ff <= nxt_cnt;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    chk_sw_pulse: assert property (rst_sel && !io_req.write |=> bus_req_withdraw &&
        rst_ind.csr_sw && rst_ind.seq_reset && register_address_port == 8'h00)
        else $error("reset port read without reset");
    chk_sw_keep: assert property (rst_ind.csr_sw |-> !rst_ind.bcr_clear &&
        !rst_ind.pcicfg_clear ##1 !eeprom_load_start)
        else $error("software reset touched wrong groups");
    chk_rst_write: assert property (rst_sel && io_req.write |=> !bus_req_withdraw)
        else $error("reset port write acted");
    chk_halt_kind: assert property (rst_ind.csr_halt |-> rst_ind.seq_reset &&
        !rst_ind.bcr_clear && !rst_ind.pcicfg_clear ##1 !eeprom_load_start)
        else $error("halt reset touched wrong groups");
    chk_halt_wait: assert property (rst_ind.csr_halt |->
        !$past(bus_req_active) && !$past(master_xfer_pending))
        else $error("halt ran while bus busy");
    chk_dword_set: assert property (io_req.valid && io_req.write && io_req.dword &&
        io_req.offset == rct_pkg::OFS_DATA_PORT && !hw_reset_hold
        |=> dword_io_mode_bit || rst_ind.csr_hw)
        else $error("dword write did not set mode");
    chk_hw_clear: assert property (rst_ind.csr_hw |=>
        !dword_io_mode_bit && register_address_port == 8'h00)
        else $error("hardware reset left mode or address");
    chk_hw_group: assert property (rst_ind.csr_hw |-> rst_ind.bcr_clear &&
        rst_ind.pcicfg_clear && rst_ind.seq_reset ##1 eeprom_load_start)
        else $error("hardware reset incomplete");
    chk_pins_in: assert property ((!reset_pin_n)[*4] |-> bus_pins_input_only)
        else $error("bus pins not inputs");
    chk_test_oe: assert property (chain_test_mode[*2] |-> !inta_oe_n)
        else $error("interrupt pin not driven in test");
    chk_chain_par: assert property (($stable({reset_pin_n, chain_pin_in}) &&
        chain_test_mode)[*5] |-> inta_o == ^(~{reset_pin_n, chain_pin_in}))
        else $error("chain output wrong");
    chk_min_width: assert property ($rose(hw_reset_hold) |-> cnt_ff >= 8'h1d)
        else $error("reset accepted too early");

    cover property (rst_ind.csr_sw);
    cover property (rst_ind.csr_halt);
    cover property (hw_reset_hold ##[1:20] rst_ind.csr_hw);
endmodule : rct_reset_ctrl_asserts

bind rct_reset_ctrl rct_reset_ctrl_asserts chk_inst (.clk_sys, .sys_rst, .reset_pin_n,
    .chain_pin_in, .inta_o, .inta_oe_n, .bus_pins_input_only, .chain_test_mode, .io_req,
    .bus_req_active, .master_xfer_pending, .rst_ind, .hw_reset_hold, .bus_req_withdraw,
    .eeprom_load_start, .dword_io_mode_bit, .register_address_port);

/* File: bench/rct_reset_ctrl_tb_top.sv */
// Testbench for rct_reset_ctrl: host ports, reset kinds, chain test.
// Assumes the bound checker and the rct_tester pin model.
`timescale 1ns/1ns
module rct_reset_ctrl_tb_top;
    typedef struct packed {
        logic [5:0] lows;
        logic       inta;
    } rct_row_t;
    logic                  clk_sys;
    logic                  sys_rst;
    logic                  reset_pin_n;
    logic                  power_good_input;
    logic [49:0]           chain_pin_in;
    logic                  inta_o;
    logic                  inta_oe_n;
    logic                  bus_pins_input_only;
    logic                  chain_test_mode;
    rct_pkg::rct_io_req_t  io_req;
    logic [31:0]           io_rdata;
    logic                  io_rvalid;
    logic                  core_inta_n;
    logic                  bus_req_active;
    logic                  master_xfer_pending;
    rct_pkg::rct_rst_ind_t rst_ind;
    logic                  hw_reset_hold;
    logic                  bus_req_withdraw;
    logic                  eeprom_load_start;
    logic                  dword_io_mode_bit;
    logic [7:0]            register_address_port;
    logic                  halt_bit;
    logic [5:0]            lows;
    logic [31:0]           rd;
    int                    fail_count;
    int                    check_count;
    int                    n;
    rct_row_t              rows [6] = '{'{6'h01, 1'h1}, '{6'h02, 1'h0}, '{6'h03, 1'h1},
                                        '{6'h1a, 1'h0}, '{6'h32, 1'h0}, '{6'h33, 1'h1}};

    rct_reset_ctrl rct_reset_ctrl_inst (.clk_sys, .sys_rst, .reset_pin_n, .power_good_input,
        .chain_pin_in, .inta_o, .inta_oe_n, .bus_pins_input_only, .chain_test_mode, .io_req,
        .io_rdata, .io_rvalid, .core_inta_n, .bus_req_active, .master_xfer_pending, .rst_ind,
        .hw_reset_hold, .bus_req_withdraw, .eeprom_load_start, .dword_io_mode_bit,
        .register_address_port, .halt_bit);
    rct_tester rct_tester_inst (.clk_sys, .lows, .reset_pin_n, .chain_pin_in);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask : tick

    // One access; outputs sampled in the cycle after it is taken
    task automatic io(input logic w, input logic d, input logic [4:0] ofs, input logic [31:0] wd);
        @(posedge clk_sys);
        io_req <= '{1'h1, w, d, ofs, wd};
        @(posedge clk_sys);
        io_req.valid <= 1'h0;
        #1;
        rd = io_rdata;
    endtask : io

    task automatic wait_ind(input logic halt);
        for (n = 0; n < 60; n++) begin
            tick;
            if ((halt ? rst_ind.csr_halt : rst_ind.csr_hw) === 1'h1) break;
        end
        if (n == 60) begin
            fail_count++;
            end_sim;
        end
    endtask : wait_ind

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        sys_rst = 1'h1;
        power_good_input = 1'h1;
        lows = 6'h00;
        io_req = '0;
        core_inta_n = 1'h1;
        bus_req_active = 1'h0;
        master_xfer_pending = 1'h0;
        fail_count = 0;
        check_count = 0;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'h0;
        wait_ind(1'h0);
        chk("por", rst_ind.por_extra, 1'h1);
        tick;
        chk("por_load", eeprom_load_start, 1'h1);
        io(1'h1, 1'h0, rct_pkg::OFS_ADDR_WORD, 32'h5);
        io(1'h1, 1'h0, rct_pkg::OFS_RESET_WORD, 32'h0);
        chk("rst_wr", bus_req_withdraw, 1'h0);
        io(1'h0, 1'h0, rct_pkg::OFS_ADDR_WORD, 32'h0);
        chk("addr_rd", rd, 32'h5);
        // Bus kept idle before the reset read, as a careful host would
        io(1'h0, 1'h0, rct_pkg::OFS_RESET_WORD, 32'h0);
        chk("rvalid", io_rvalid, 1'h1);
        chk("sw_req", bus_req_withdraw, 1'h1);
        chk("sw_ind", {rst_ind.csr_sw, rst_ind.seq_reset, rst_ind.bcr_clear}, 3'h6);
        chk("sw_addr", register_address_port, 8'h00);
        tick;
        chk("sw_load", eeprom_load_start, 1'h0);
        @(posedge clk_sys);
        bus_req_active <= 1'h1;
        master_xfer_pending <= 1'h1;
        core_inta_n <= 1'h0;
        io(1'h1, 1'h0, rct_pkg::OFS_DATA_PORT, 32'h4);
        chk("halt", halt_bit, 1'h1);
        chk("oe_core", inta_oe_n, 1'h0);
        @(posedge clk_sys);
        bus_req_active <= 1'h0;
        repeat (4) begin
            tick;
            chk("early", rst_ind.csr_halt, 1'h0);
        end
        @(posedge clk_sys);
        master_xfer_pending <= 1'h0;
        core_inta_n <= 1'h1;
        wait_ind(1'h1);
        chk("halt_ind", {rst_ind.seq_reset, rst_ind.csr_sw, rst_ind.bcr_clear}, 3'h4);
        io(1'h0, 1'h0, rct_pkg::OFS_DATA_PORT, 32'h0);
        chk("csr0", rd[2], 1'h1);
        chk("oe_idle", {inta_oe_n, inta_o}, 2'h2);
        io(1'h1, 1'h0, rct_pkg::OFS_DATA_PORT, 32'h4);
        repeat (4) begin
            tick;
            chk("rehalt", rst_ind.csr_halt, 1'h0);
        end
        io(1'h1, 1'h0, rct_pkg::OFS_DATA_PORT, 32'h1);
        chk("unhalt", halt_bit, 1'h0);
        io(1'h1, 1'h1, rct_pkg::OFS_DATA_PORT, 32'h0);
        chk("dword", dword_io_mode_bit, 1'h1);
        io(1'h0, 1'h1, rct_pkg::OFS_ADDR_DWORD, 32'h0);
        chk("no_rst", bus_req_withdraw, 1'h0);
        io(1'h0, 1'h1, rct_pkg::OFS_RESET_DWORD, 32'h0);
        chk("dw_rst", bus_req_withdraw, 1'h1);
        chk("dw_keep", dword_io_mode_bit, 1'h1);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            lows <= rows[i].lows;
            repeat (6) tick;
            chk("chain", inta_o, rows[i].inta);
            chk("test_oe", inta_oe_n, 1'h0);
            chk("pins_in", bus_pins_input_only, 1'h1);
            chk("test", chain_test_mode, 1'h1);
        end
        chk("hold", hw_reset_hold, 1'h1);
        @(posedge clk_sys);
        lows <= 6'h00;
        wait_ind(1'h0);
        chk("hw_ind", {rst_ind.bcr_clear, rst_ind.pcicfg_clear, rst_ind.por_extra}, 3'h6);
        tick;
        chk("hw_load", eeprom_load_start, 1'h1);
        chk("hw_dw", {dword_io_mode_bit, register_address_port}, 9'h000);
        @(posedge clk_sys);
        lows <= 6'h01;
        repeat (10) @(posedge clk_sys);
        lows <= 6'h00;
        power_good_input <= 1'h0;
        repeat (20) begin
            tick;
            chk("short", rst_ind.csr_hw, 1'h0);
        end
        @(posedge clk_sys);
        lows <= 6'h01;
        repeat (40) tick;
        chk("pg_low", {chain_test_mode, hw_reset_hold}, 2'h0);
        @(posedge clk_sys);
        lows <= 6'h00;
        repeat (20) begin
            tick;
            chk("pg_rst", rst_ind.csr_hw, 1'h0);
        end
        end_sim;
    end
endmodule : rct_reset_ctrl_tb_top

/* File: bench/rct_tester.sv */
// Board tester model: drives the reset pin and the chain pins.
// Assumes lows counts chain inputs held low, in chain order.
`timescale 1ns/1ns
module rct_tester (
    // Clock
    input  wire logic        clk_sys,
    // Request from the bench
    input  wire logic [5:0]  lows,
    // Pins toward the device
    output logic             reset_pin_n,
    output logic [49:0]      chain_pin_in
);
    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Released pins sit high on their pull-ups
    initial begin
        reset_pin_n = 1'b1;
        chain_pin_in = '1;
    end

    // Reset pin is low whenever any chain pin is low, and changes on the same edge as them
    always @(posedge clk_sys) begin
        reset_pin_n <= (lows == 6'h00);
        for (int i = 0; i < 50; i++) begin
            chain_pin_in[i] <= (lows < 6'(i + 2));
        end
    end
endmodule : rct_tester

/* File: inc/rct_pkg.sv */
// Constants and types for the reset controller and pin chain test.
// Assumes a 100 MHz system clock and a 5-bit I/O offset from the core decoder.
package rct_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int RST_MIN_PULSE_NS = 300;
    localparam int RST_MIN_CYC     = (RST_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 8;

    // ------------------------------------------------------------------
    // Chain
    // ------------------------------------------------------------------
    localparam int CHAIN_LEN       = 51;

    // ------------------------------------------------------------------
    // I/O offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_DATA_PORT   = 5'h10;
    localparam logic [4:0] OFS_ADDR_WORD   = 5'h12;
    localparam logic [4:0] OFS_ADDR_DWORD  = 5'h14;
    localparam logic [4:0] OFS_RESET_WORD  = 5'h14;
    localparam logic [4:0] OFS_RESET_DWORD = 5'h18;

    // ------------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------------
    localparam int         ADDR_W          = 8;
    localparam logic [7:0] ADDR_RESET_VAL  = 8'h00;
    localparam logic [7:0] CSR0_INDEX      = 8'h00;
    localparam int         BIT_INIT        = 0;
    localparam int         BIT_START       = 1;
    localparam int         BIT_HALT        = 2;
    localparam int         BIT_DWORD_IO    = 7;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        HW_IDLE  = 2'b00,
        HW_COUNT = 2'b01,
        HW_HELD  = 2'b11,
        HW_LOAD  = 2'b10
    } rct_hw_state_t;

    // One-cycle reset-kind pulses toward each register group
    typedef struct packed {
        logic csr_hw;
        logic csr_sw;
        logic csr_halt;
        logic por_extra;
        logic bcr_clear;
        logic pcicfg_clear;
        logic seq_reset;
    } rct_rst_ind_t;

    // Host access from the core address decoder
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        dword;
        logic [4:0]  offset;
        logic [31:0] wdata;
    } rct_io_req_t;

endpackage : rct_pkg

/* File: verilog/rct_reset_ctrl.sv */
// Reset kind sequencing, register address/data port handling and pin chain test.
// Assumes the core decoder presents one I/O access per cycle already in clk_sys.
`timescale 1ns/1ns

module rct_reset_ctrl (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    // Pins
    input  wire logic                 reset_pin_n,
    input  wire logic                 power_good_input,
    input  wire logic [49:0]          chain_pin_in,
    // Interrupt pin, bus pin direction and chain test mode
    output logic                      inta_o,
    output logic                      inta_oe_n,
    output logic                      bus_pins_input_only,
    output logic                      chain_test_mode,
    // Host I/O access
    input  rct_pkg::rct_io_req_t      io_req,
    output logic [31:0]               io_rdata,
    output logic                      io_rvalid,
    // Core interrupt and bus master status
    input  wire logic                 core_inta_n,
    input  wire logic                 bus_req_active,
    input  wire logic                 master_xfer_pending,
    // Reset outputs
    output rct_pkg::rct_rst_ind_t     rst_ind,
    output logic                      hw_reset_hold,
    output logic                      bus_req_withdraw,
    output logic                      eeprom_load_start,
    output logic                      dword_io_mode_bit,
    output logic [rct_pkg::ADDR_W-1:0] register_address_port,
    output logic                      halt_bit
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [rct_pkg::CHAIN_LEN-1:0] pin_meta_ff;
    logic [rct_pkg::CHAIN_LEN-1:0] pin_sync_ff;
    logic                          pg_meta_ff;
    logic                          pg_sync_ff;

    always_ff @(posedge clk_sys) begin
        pin_meta_ff <= {chain_pin_in, reset_pin_n};
        pin_sync_ff <= pin_meta_ff;
        pg_meta_ff  <= power_good_input;
        pg_sync_ff  <= pg_meta_ff;
    end
    logic rst_pin_low;
    assign rst_pin_low = ~pin_sync_ff[0];

    // ------------------------------------------------------------------
    // Pin chain
    // ------------------------------------------------------------------
    // Each stage flips the running value on a low input, so the output
    // toggles with every added low and any stuck pin shows up.
    wire  [rct_pkg::CHAIN_LEN-1:0] chain_node;
    assign chain_node[0] = ~pin_sync_ff[0];
    genvar gi;
    generate
        for (gi = 1; gi < rct_pkg::CHAIN_LEN; gi++) begin : g_chain
            assign chain_node[gi] = chain_node[gi-1] ^ ~pin_sync_ff[gi];
        end
    endgenerate
    logic test_mode;
    assign test_mode = rst_pin_low & pg_sync_ff;
    logic inta_ff;
    logic nxt_inta;
    logic oe_n_ff;
    logic nxt_oe_n;
    logic inputs_only_ff;
    logic nxt_inputs_only;

    always_comb begin
        nxt_inputs_only = rst_pin_low;
        if (test_mode) begin
            nxt_inta = chain_node[rct_pkg::CHAIN_LEN-1];
            nxt_oe_n = 1'b0;
        end else begin
            nxt_inta = 1'b0;
            nxt_oe_n = core_inta_n;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            inta_ff        <= 1'b0;
            oe_n_ff        <= 1'b1;
            inputs_only_ff <= 1'b1;
        end else begin
            inta_ff        <= nxt_inta;
            oe_n_ff        <= nxt_oe_n;
            inputs_only_ff <= nxt_inputs_only;
        end
    end

    assign inta_o              = inta_ff;
    assign inta_oe_n           = oe_n_ff;
    assign bus_pins_input_only = inputs_only_ff;
    assign chain_test_mode     = test_mode;

    // ------------------------------------------------------------------
    // Hardware reset and power-up sequencing
    // ------------------------------------------------------------------
    rct_pkg::rct_hw_state_t     hw_state_ff;
    rct_pkg::rct_hw_state_t     nxt_hw_state;
    logic [rct_pkg::CNT_W-1:0]  width_cnt_ff;
    logic [rct_pkg::CNT_W-1:0]  nxt_width_cnt;
    logic                       por_pending_ff;
    logic                       nxt_por_pending;
    logic                       hw_pulse;
    logic                       por_pulse;
    logic                       load_pulse;
    localparam logic [rct_pkg::CNT_W-1:0] MIN_CNT = rct_pkg::CNT_W'(rct_pkg::RST_MIN_CYC - 1);
    always_comb begin
        nxt_hw_state    = hw_state_ff;
        nxt_width_cnt   = width_cnt_ff;
        nxt_por_pending = por_pending_ff;
        hw_pulse        = 1'b0;
        por_pulse       = 1'b0;
        load_pulse      = 1'b0;
        case (hw_state_ff)
            rct_pkg::HW_IDLE: begin
                nxt_width_cnt = '0;
                if (por_pending_ff) begin
                    hw_pulse        = 1'b1;
                    por_pulse       = 1'b1;
                    nxt_por_pending = 1'b0;
                    nxt_hw_state    = rct_pkg::HW_LOAD;
                end else if (test_mode) begin
                    nxt_hw_state = rct_pkg::HW_COUNT;
                end
            end
            rct_pkg::HW_COUNT: begin
                if (!test_mode) begin
                    nxt_hw_state = rct_pkg::HW_IDLE;
                end else if (width_cnt_ff == MIN_CNT) begin
                    nxt_hw_state = rct_pkg::HW_HELD;
                end else begin
                    nxt_width_cnt = width_cnt_ff + 1'b1;
                end
            end
            rct_pkg::HW_HELD: begin
                if (!rst_pin_low) begin
                    hw_pulse     = 1'b1;
                    nxt_hw_state = rct_pkg::HW_LOAD;
                end
            end
            rct_pkg::HW_LOAD: begin
                load_pulse   = 1'b1;
                nxt_hw_state = rct_pkg::HW_IDLE;
            end
            default: begin
                nxt_hw_state = rct_pkg::HW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            hw_state_ff    <= rct_pkg::HW_IDLE;
            width_cnt_ff   <= '0;
            por_pending_ff <= 1'b1;
        end else begin
            hw_state_ff    <= nxt_hw_state;
            width_cnt_ff   <= nxt_width_cnt;
            por_pending_ff <= nxt_por_pending;
        end
    end

    // ------------------------------------------------------------------
    // Host port decode
    // ------------------------------------------------------------------
    logic        dword_ff;
    logic        nxt_dword;
    logic [7:0]  addr_ff;
    logic [7:0]  nxt_addr;
    logic        halt_ff;
    logic        nxt_halt;
    logic        halt_wait_ff;
    logic        nxt_halt_wait;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic        sw_pulse;
    logic        halt_pulse;
    logic [4:0]  ofs_addr;
    logic [4:0]  ofs_reset;
    logic        rd;
    logic        wr;
    logic        csr0_sel;

    assign ofs_addr  = dword_ff ? rct_pkg::OFS_ADDR_DWORD : rct_pkg::OFS_ADDR_WORD;
    assign ofs_reset = dword_ff ? rct_pkg::OFS_RESET_DWORD : rct_pkg::OFS_RESET_WORD;
    assign rd        = io_req.valid & ~io_req.write;
    assign wr        = io_req.valid & io_req.write;
    assign csr0_sel  = (addr_ff == rct_pkg::CSR0_INDEX);

    always_comb begin
        nxt_dword     = dword_ff;
        nxt_addr      = addr_ff;
        nxt_halt      = halt_ff;
        nxt_halt_wait = halt_wait_ff;
        nxt_rdata     = rdata_ff;
        nxt_rvalid    = rd;
        sw_pulse      = 1'b0;
        halt_pulse    = 1'b0;
        if (rd) begin
            nxt_rdata = '0;
            if (io_req.offset == ofs_reset) begin
                sw_pulse = 1'b1;
            end else if (io_req.offset == ofs_addr) begin
                nxt_rdata[rct_pkg::ADDR_W-1:0] = addr_ff;
            end else if (io_req.offset == rct_pkg::OFS_DATA_PORT && csr0_sel) begin
                nxt_rdata[rct_pkg::BIT_HALT] = halt_ff;
            end
        end
        if (wr) begin
            // Reset port writes fall through with no effect
            if (io_req.offset == rct_pkg::OFS_DATA_PORT) begin
                if (io_req.dword) begin
                    nxt_dword = 1'b1;
                end
                if (csr0_sel) begin
                    if (io_req.wdata[rct_pkg::BIT_HALT] && !halt_ff) begin
                        nxt_halt      = 1'b1;
                        nxt_halt_wait = 1'b1;
                    end else if (!io_req.wdata[rct_pkg::BIT_HALT] &&
                                 (io_req.wdata[rct_pkg::BIT_INIT] ||
                                  io_req.wdata[rct_pkg::BIT_START])) begin
                        nxt_halt = 1'b0;
                    end
                end
            end else if (io_req.offset == ofs_addr) begin
                nxt_addr = io_req.wdata[rct_pkg::ADDR_W-1:0];
            end
        end
        // Pending master work finishes before the halt takes effect
        if (halt_wait_ff && !bus_req_active && !master_xfer_pending) begin
            halt_pulse    = 1'b1;
            nxt_halt_wait = 1'b0;
        end
        if (sw_pulse) begin
            nxt_addr      = rct_pkg::ADDR_RESET_VAL;
            nxt_halt_wait = 1'b0;
        end
        if (hw_pulse) begin
            nxt_addr      = rct_pkg::ADDR_RESET_VAL;
            nxt_dword     = 1'b0;
            nxt_halt      = 1'b0;
            nxt_halt_wait = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dword_ff     <= 1'b0;
            addr_ff      <= rct_pkg::ADDR_RESET_VAL;
            halt_ff      <= 1'b0;
            halt_wait_ff <= 1'b0;
            rdata_ff     <= '0;
            rvalid_ff    <= 1'b0;
        end else begin
            dword_ff     <= nxt_dword;
            addr_ff      <= nxt_addr;
            halt_ff      <= nxt_halt;
            halt_wait_ff <= nxt_halt_wait;
            rdata_ff     <= nxt_rdata;
            rvalid_ff    <= nxt_rvalid;
        end
    end

    // ------------------------------------------------------------------
    // Reset-kind distribution
    // ------------------------------------------------------------------
    rct_pkg::rct_rst_ind_t ind_ff;
    rct_pkg::rct_rst_ind_t nxt_ind;
    logic                  withdraw_ff;
    logic                  load_ff;

    always_comb begin
        nxt_ind              = '0;
        nxt_ind.csr_hw       = hw_pulse;
        nxt_ind.por_extra    = por_pulse;
        nxt_ind.bcr_clear    = hw_pulse;
        nxt_ind.pcicfg_clear = hw_pulse;
        nxt_ind.csr_sw       = sw_pulse & ~hw_pulse;
        nxt_ind.csr_halt     = halt_pulse & ~hw_pulse & ~sw_pulse;
        nxt_ind.seq_reset    = hw_pulse | sw_pulse | halt_pulse;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ind_ff      <= '0;
            withdraw_ff <= 1'b0;
            load_ff     <= 1'b0;
        end else begin
            ind_ff      <= nxt_ind;
            withdraw_ff <= sw_pulse;
            load_ff     <= load_pulse;
        end
    end

    assign rst_ind               = ind_ff;
    assign bus_req_withdraw      = withdraw_ff;
    assign eeprom_load_start     = load_ff;
    assign hw_reset_hold         = (hw_state_ff == rct_pkg::HW_HELD);
    assign dword_io_mode_bit     = dword_ff;
    assign register_address_port = addr_ff;
    assign halt_bit              = halt_ff;
    assign io_rdata              = rdata_ff;
    assign io_rvalid             = rvalid_ff;

endmodule : rct_reset_ctrl
